// [src/flash_protect_pkg.sv]
/*
  Constants shared by the serial flash protection and reset command logic.
  Assumes a 100 MHz system clock that oversamples the serial link clock.
*/
package flash_protect_pkg;
  // ------------------------------------------------------------
  // opcodes
  // ------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_WRITE_SECURITY = 8'h2f;
  localparam logic [7:0] OP_PROTECT_SELECT = 8'h68;
  localparam logic [7:0] OP_BLOCK_LOCK = 8'h36;
  localparam logic [7:0] OP_BLOCK_UNLOCK = 8'h39;
  localparam logic [7:0] OP_READ_BLOCK_LOCK = 8'h3c;
  localparam logic [7:0] OP_GANG_LOCK = 8'h7e;
  localparam logic [7:0] OP_GANG_UNLOCK = 8'h98;
  localparam logic [7:0] OP_BUSY_OUT_ENABLE = 8'h70;
  localparam logic [7:0] OP_BUSY_OUT_DISABLE = 8'h80;
  localparam logic [7:0] OP_NO_OPERATION = 8'h00;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  // ------------------------------------------------------------
  // security and status register fields
  // ------------------------------------------------------------
  localparam int SEC_PROTECT_SELECT_BIT = 7;
  localparam int SEC_PROGRAM_MODE_BIT = 4;
  localparam int SEC_LOCKDOWN_BIT = 1;
  localparam int SEC_FACTORY_LOCK_BIT = 0;
  localparam int STATUS_WRITE_DISABLE_BIT = 7;
  // ------------------------------------------------------------
  // address fields and timing
  // ------------------------------------------------------------
  localparam int ADDR_BLOCK_MSB = 23;
  localparam int ADDR_BLOCK_LSB = 16;
  localparam int ADDR_SECTOR_LSB = 12;
  localparam int ADDR_BYTES = 3;
  localparam int CLK_MHZ = 100;
  localparam int RESET_RECOVER_US = 12;
  localparam int RESET_RECOVER_PROG_US = 40;
  localparam int RESET_RECOVER_CYCLES = RESET_RECOVER_US * CLK_MHZ;
  localparam int RESET_RECOVER_PROG_CYCLES = RESET_RECOVER_PROG_US * CLK_MHZ;
endpackage

// [src/flash_sync_edge.sv]
/*
  Two-flop synchroniser with rise and fall pulses for one pin.
  Assumes the input is asynchronous to clock.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_sync_edge #(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  // ------------------------------------------------------------
  // two flops then an edge detector
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      meta_q <= RESET_VALUE;
      sync_q <= RESET_VALUE;
      last_q <= RESET_VALUE;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;
endmodule
`default_nettype wire

// [src/flash_sector_locks.sv]
/*
  Volatile per-sector lock bit array with single and gang update.
  Assumes update strobes come one cycle at a time from the decoder.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_sector_locks #(
  parameter int SECTOR_BITS = 12
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic set_all,
  input wire logic clear_all,
  input wire logic write_one,
  input wire logic write_value,
  input wire logic [SECTOR_BITS-1:0] write_index,
  input wire logic [SECTOR_BITS-1:0] read_index,
  output logic read_value
);
  logic [(1<<SECTOR_BITS)-1:0] lock_q;

  // ------------------------------------------------------------
  // lock array, all ones on reset
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      lock_q <= '1;
    end else if (set_all) begin
      lock_q <= '1;
    end else if (clear_all) begin
      lock_q <= '0;
    end else if (write_one) begin
      lock_q[write_index] <= write_value;
    end
  end

  assign read_value = lock_q[read_index];
endmodule
`default_nettype wire

// [src/flash_protect_cmds.sv]
/*
  Protection, security and software reset command engine of a serial
  flash. Assumes mode 0 framing: data sampled on the link clock rise,
  driven on its fall; the link clock is far slower than clock.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_protect_cmds #(
  parameter int SECTOR_BITS = 12,
  parameter int RECOVER_CYCLES = flash_protect_pkg::RESET_RECOVER_CYCLES,
  parameter int RECOVER_PROG_CYCLES =
    flash_protect_pkg::RESET_RECOVER_PROG_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic serial_in,
  input wire logic [2:0] upper_io_lines,
  input wire logic write_protect_pin_n,
  input wire logic status_write_disable,
  input wire logic continuous_program_mode,
  input wire logic array_busy,
  input wire logic program_active,
  input wire logic protect_select_nv,
  input wire logic otp_lockdown_nv,
  input wire logic factory_lock_nv,
  input wire logic [SECTOR_BITS-1:0] query_sector,
  output logic serial_out,
  output logic serial_out_en,
  output logic [7:0] security_reg,
  output logic protection_select,
  output logic otp_lockdown_bit,
  output logic write_latch,
  output logic level_bits_frozen,
  output logic query_protected,
  output logic abort_operation,
  output logic device_ready
);
  localparam int RC_W = $clog2(RECOVER_PROG_CYCLES + 1);

  initial begin
    if (SECTOR_BITS < 1 || SECTOR_BITS > 12) begin
      $error("SECTOR_BITS must lie in 1..12");
    end
    if (RECOVER_PROG_CYCLES <= RECOVER_CYCLES || RECOVER_CYCLES < 1) begin
      $error("program recovery must exceed other recovery");
    end
  end

  typedef enum logic [1:0] {
    ph_opcode,
    ph_address,
    ph_output,
    ph_ignore
  } phase_e;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic cs_n;
  logic cs_rise;
  logic cs_fall;
  logic sck_rise;
  logic sck_fall;
  logic si;
  logic wp_n;

  flash_sync_edge #(.RESET_VALUE(1'b1)) sync_cs (
    .clock(clock), .reset(reset), .pin(chip_select_n),
    .level(cs_n), .rise(cs_rise), .fall(cs_fall));
  flash_sync_edge #(.RESET_VALUE(1'b0)) sync_sck (
    .clock(clock), .reset(reset), .pin(serial_clock),
    .level(), .rise(sck_rise), .fall(sck_fall));
  flash_sync_edge #(.RESET_VALUE(1'b0)) sync_si (
    .clock(clock), .reset(reset), .pin(serial_in),
    .level(si), .rise(), .fall());
  flash_sync_edge #(.RESET_VALUE(1'b1)) sync_wp (
    .clock(clock), .reset(reset), .pin(write_protect_pin_n),
    .level(wp_n), .rise(), .fall());

  // upper lines are don't care for every command here
  logic unused_upper;
  assign unused_upper = ^upper_io_lines;

  // ------------------------------------------------------------
  // shifter, bit count and phase
  // ------------------------------------------------------------
  phase_e phase_q;
  logic [7:0] shift_q;
  logic [2:0] bit_q;
  logic [1:0] addr_cnt_q;
  logic [7:0] opcode_q;
  logic [23:0] addr_q;
  logic soft_reset; // pulse: software reset executed
  logic recovering_q;

  wire logic [7:0] byte_in = {shift_q[6:0], si};
  wire logic byte_done = sck_rise && !cs_n && bit_q == 3'd7;
  wire logic need_addr =
    byte_in == flash_protect_pkg::OP_BLOCK_LOCK ||
    byte_in == flash_protect_pkg::OP_BLOCK_UNLOCK ||
    byte_in == flash_protect_pkg::OP_READ_BLOCK_LOCK;

  // bit counter, clears on each new frame
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      bit_q <= 3'd0;
      shift_q <= 8'h00;
    end else if (cs_fall || cs_n) begin
      bit_q <= 3'd0;
    end else if (sck_rise) begin
      bit_q <= bit_q + 3'd1;
      shift_q <= byte_in;
    end
  end

  // frame phase and captured opcode and address
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      phase_q <= ph_opcode;
      opcode_q <= 8'h00;
      addr_q <= 24'h000000;
      addr_cnt_q <= 2'd0;
    end else if (cs_n) begin
      phase_q <= ph_opcode;
      addr_cnt_q <= 2'd0;
    end else if (byte_done) begin
      case (phase_q)
        ph_opcode: begin
          opcode_q <= byte_in;
          phase_q <= (recovering_q) ? ph_ignore :
                     (need_addr) ? ph_address : ph_ignore;
        end
        ph_address: begin
          addr_q <= {addr_q[15:0], byte_in};
          addr_cnt_q <= addr_cnt_q + 2'd1;
          if (addr_cnt_q == 2'(flash_protect_pkg::ADDR_BYTES - 1)) begin
            phase_q <= (opcode_q == flash_protect_pkg::OP_READ_BLOCK_LOCK)
                       ? ph_output : ph_ignore;
          end
        end
        default: begin
          phase_q <= ph_ignore;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // completion decode on chip select rise
  // ------------------------------------------------------------
  // frame is whole when select rises on a byte boundary
  wire logic on_boundary = cs_rise && bit_q == 3'd0;
  wire logic opcode_only = on_boundary && phase_q == ph_ignore &&
    addr_cnt_q == 2'd0 && !recovering_q;
  wire logic address_done = on_boundary && phase_q == ph_ignore &&
    addr_cnt_q == 2'(flash_protect_pkg::ADDR_BYTES) && !recovering_q;
  wire logic per_block = protection_select;
  wire logic is_op = opcode_only || address_done;
  wire logic do_latch_set = opcode_only &&
    opcode_q == flash_protect_pkg::OP_WRITE_LATCH_SET;
  wire logic do_sec_write = opcode_only && write_latch &&
    opcode_q == flash_protect_pkg::OP_WRITE_SECURITY;
  wire logic do_select = opcode_only && write_latch &&
    opcode_q == flash_protect_pkg::OP_PROTECT_SELECT;
  wire logic do_gang_lock = opcode_only && write_latch && per_block &&
    opcode_q == flash_protect_pkg::OP_GANG_LOCK;
  wire logic do_gang_unlock = opcode_only && write_latch && per_block &&
    opcode_q == flash_protect_pkg::OP_GANG_UNLOCK;
  wire logic do_single = address_done && write_latch && per_block &&
    (opcode_q == flash_protect_pkg::OP_BLOCK_LOCK ||
     opcode_q == flash_protect_pkg::OP_BLOCK_UNLOCK);
  wire logic do_busy_on = opcode_only && continuous_program_mode &&
    opcode_q == flash_protect_pkg::OP_BUSY_OUT_ENABLE;
  wire logic do_busy_off = opcode_only && continuous_program_mode &&
    opcode_q == flash_protect_pkg::OP_BUSY_OUT_DISABLE;
  wire logic do_arm = opcode_only &&
    opcode_q == flash_protect_pkg::OP_RESET_ARM;
  wire logic do_sec_write_ok = do_sec_write && !otp_lockdown_bit;

  // ------------------------------------------------------------
  // software reset arming
  // ------------------------------------------------------------
  logic armed_q;

  // any frame other than arm disarms, the executed reset itself included
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      armed_q <= 1'b0;
    end else if (soft_reset) begin
      armed_q <= 1'b0;
    end else if (do_arm) begin
      armed_q <= 1'b1;
    end else if (cs_rise) begin
      armed_q <= 1'b0;
    end
  end

  assign soft_reset = opcode_only && armed_q &&
    opcode_q == flash_protect_pkg::OP_RESET;

  // recovery counter, longer after an aborted program
  logic [RC_W-1:0] recover_q;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      recover_q <= '0;
      recovering_q <= 1'b0;
      abort_operation <= 1'b0;
    end else begin
      abort_operation <= soft_reset && array_busy;
      if (soft_reset) begin
        recovering_q <= 1'b1;
        recover_q <= program_active ?
          RC_W'(RECOVER_PROG_CYCLES - 1) :
          RC_W'(RECOVER_CYCLES - 1);
      end else if (recover_q != '0) begin
        recover_q <= recover_q - RC_W'(1);
      end else begin
        recovering_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // write latch, select and lock-down bits
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      write_latch <= 1'b0;
    end else if (soft_reset) begin
      write_latch <= 1'b0;
    end else if (do_latch_set) begin
      write_latch <= 1'b1;
    end else if (do_sec_write || do_select || do_gang_lock ||
                 do_gang_unlock || do_single) begin
      write_latch <= 1'b0;
    end
  end

  // one-time bits load from storage after reset, then only set
  logic loaded_q;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      loaded_q <= 1'b0;
      protection_select <= 1'b0;
      otp_lockdown_bit <= 1'b0;
    end else if (!loaded_q) begin
      loaded_q <= 1'b1;
      protection_select <= protect_select_nv;
      otp_lockdown_bit <= otp_lockdown_nv;
    end else begin
      if (do_select) begin
        protection_select <= 1'b1;
      end
      if (do_sec_write_ok) begin
        otp_lockdown_bit <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // per-block lock array
  // ------------------------------------------------------------
  logic lock_read;
  logic [SECTOR_BITS-1:0] sel_index;
  logic [SECTOR_BITS-1:0] frame_index;

  assign frame_index = addr_q[flash_protect_pkg::ADDR_BLOCK_MSB -:
                              SECTOR_BITS];
  assign sel_index = (phase_q == ph_output) ? frame_index : query_sector;

  flash_sector_locks #(.SECTOR_BITS(SECTOR_BITS)) locks (
    .clock(clock),
    .reset(reset),
    .set_all(do_gang_lock || soft_reset || (!loaded_q && 1'b1)),
    .clear_all(do_gang_unlock),
    .write_one(do_single),
    .write_value(opcode_q == flash_protect_pkg::OP_BLOCK_LOCK),
    .write_index(frame_index),
    .read_index(sel_index),
    .read_value(lock_read)
  );

  // effective protection of the queried sector
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      query_protected <= 1'b1;
      level_bits_frozen <= 1'b0;
    end else begin
      query_protected <= per_block && (lock_read || !wp_n);
      level_bits_frozen <= !per_block && status_write_disable &&
        !wp_n;
    end
  end

  // ------------------------------------------------------------
  // busy output enable
  // ------------------------------------------------------------
  logic busy_out_q;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      busy_out_q <= 1'b0;
    end else if (soft_reset || !continuous_program_mode) begin
      busy_out_q <= 1'b0;
    end else if (do_busy_on) begin
      busy_out_q <= 1'b1;
    end else if (do_busy_off) begin
      busy_out_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // serial out: lock status byte or ready/busy level
  // ------------------------------------------------------------
  logic [7:0] out_shift_q;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      out_shift_q <= 8'h00;
      serial_out <= 1'b0;
      serial_out_en <= 1'b0;
    end else if (cs_n) begin
      serial_out_en <= 1'b0;
      serial_out <= 1'b0;
      if (busy_out_q) begin
        serial_out_en <= 1'b1;
        serial_out <= !array_busy;
      end
    end else if (phase_q == ph_output && sck_fall) begin
      if (bit_q == 3'd0) begin
        // first byte holds the lock status in every bit
        out_shift_q <= {7'h00, per_block && lock_read};
        serial_out <= per_block && lock_read;
      end else begin
        serial_out <= out_shift_q[0];
      end
      serial_out_en <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // security register image and readiness
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      security_reg <= 8'h00;
      device_ready <= 1'b0;
    end else begin
      security_reg <= 8'h00;
      security_reg[flash_protect_pkg::SEC_PROTECT_SELECT_BIT] <=
        protection_select;
      security_reg[flash_protect_pkg::SEC_PROGRAM_MODE_BIT] <=
        continuous_program_mode;
      security_reg[flash_protect_pkg::SEC_LOCKDOWN_BIT] <=
        otp_lockdown_bit;
      security_reg[flash_protect_pkg::SEC_FACTORY_LOCK_BIT] <=
        factory_lock_nv;
      device_ready <= loaded_q && !recovering_q && !soft_reset;
    end
  end

  logic unused_misc;
  assign unused_misc = is_op;
endmodule
`default_nettype wire

// [test/flash_protect_chk.sv]
/*
  Concurrent checks on the protection command engine ports.
  Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_protect_chk #(
  parameter int RECOVER_PROG_CYCLES = 30
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic chip_select_n,
  input wire logic write_protect_pin_n,
  input wire logic continuous_program_mode,
  input wire logic serial_out_en,
  input wire logic [7:0] security_reg,
  input wire logic protection_select,
  input wire logic otp_lockdown_bit,
  input wire logic write_latch,
  input wire logic level_bits_frozen,
  input wire logic query_protected,
  input wire logic abort_operation,
  input wire logic device_ready
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic [15:0] low_q;
  // length of the current not-ready stretch
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      low_q <= 16'h0;
    end else if (device_ready) begin
      low_q <= 16'h0;
    end else begin
      low_q <= low_q + 16'h1;
    end
  end
  a_select_sticky: assert property (
    $past(protection_select) |-> protection_select)
    else $error("protection select returned to zero");
  a_sec_mirror: assert property (
    security_reg[7] == $past(protection_select) &&
    security_reg[1] == $past(otp_lockdown_bit))
    else $error("security bits differ from level outputs");
  a_level_off: assert property (
    $past(protection_select, 2) |-> !level_bits_frozen)
    else $error("level freeze active in per-block mode");
  a_pin_protects: assert property (
    (protection_select && !write_protect_pin_n) [*5] |-> query_protected)
    else $error("pin low left a sector writable");
  a_select_latch: assert property (
    $rose(protection_select) |-> ##[0:2] !write_latch)
    else $error("write latch kept after protection select");
  a_lockdown_latch: assert property (
    $rose(otp_lockdown_bit) |-> ##[0:2] !write_latch)
    else $error("write latch kept after security write");
  a_abort_pulse: assert property (
    abort_operation |=> !abort_operation)
    else $error("abort longer than one cycle");
  a_abort_ready: assert property (
    abort_operation |-> ##[0:2] !device_ready)
    else $error("abort without recovery");
  a_recover_min: assert property (
    $fell(device_ready) |-> !device_ready [*8])
    else $error("recovery too short");
  a_recover_max: assert property (
    low_q <= RECOVER_PROG_CYCLES + 8)
    else $error("recovery too long");
  a_busy_quiet: assert property (
    (!continuous_program_mode && chip_select_n) [*8] |-> !serial_out_en)
    else $error("serial out driven outside program mode");
endmodule
bind flash_protect_cmds flash_protect_chk #(
  .RECOVER_PROG_CYCLES(RECOVER_PROG_CYCLES)
) chk_i (.clock, .reset, .chip_select_n, .write_protect_pin_n,
  .continuous_program_mode, .serial_out_en, .security_reg,
  .protection_select, .otp_lockdown_bit, .write_latch,
  .level_bits_frozen, .query_protected, .abort_operation, .device_ready);
`default_nettype wire

// [test/flash_host_model.sv]
/*
  Host serial controller model: mode 0 frames, MSB first.
  Assumes clock is the 100 MHz bench clock; link clock is 160 ns.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
  input wire logic clock,
  input wire logic serial_out,
  output logic chip_select_n,
  output logic serial_clock,
  output logic serial_in
);
  // ------------------------------------------------------------
  // frame driver
  // ------------------------------------------------------------
  localparam int HALF = 8;
  // link clock idles low, data line shows no stale value
  initial begin
    chip_select_n = 1'b1;
    serial_clock = 1'b0;
    serial_in = 1'b0;
  end
  // nbits from the top of word, then 8 bits read back when rd
  task automatic frame(input logic [31:0] word, input int nbits,
                       input logic rd, output logic [7:0] rx);
    int total;
    total = rd ? nbits + 8 : nbits;
    rx = 8'h0;
    @(negedge clock);
    chip_select_n = 1'b0;
    for (int i = 0; i < total; i++) begin
      serial_in = (i < nbits) ? word[31-i] : ~serial_in;
      repeat (HALF) @(negedge clock);
      serial_clock = 1'b1;
      rx = {rx[6:0], serial_out};
      repeat (HALF) @(negedge clock);
      serial_clock = 1'b0;
    end
    repeat (HALF) @(negedge clock);
    chip_select_n = 1'b1; // rise placed by nbits
    serial_in = ~serial_in;
  endtask
endmodule
`default_nettype wire

// [test/test_flash_protect_cmds.sv]
/*
  Bench for the protection command engine: command frames and checks.
  Assumes the host model and checker files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_flash_protect_cmds;
  // ------------------------------------------------------------
  // bench
  // ------------------------------------------------------------
  localparam int REC = 10;
  localparam int REC_PROG = 30;
  logic clock, reset, chip_select_n, serial_clock, serial_in;
  logic write_protect_pin_n, status_write_disable;
  logic continuous_program_mode, array_busy, program_active;
  logic protect_select_nv, serial_out, serial_out_en, protection_select;
  logic otp_lockdown_bit, write_latch, level_bits_frozen;
  logic query_protected, abort_operation, device_ready;
  logic [2:0] upper_io_lines = 3'h0;
  logic [11:0] query_sector;
  logic [7:0] security_reg, rx;
  int failures = 0;
  int checked = 0;
  flash_protect_cmds #(.SECTOR_BITS(12), .RECOVER_CYCLES(REC),
    .RECOVER_PROG_CYCLES(REC_PROG)) dut (.clock, .reset, .chip_select_n,
    .serial_clock, .serial_in, .upper_io_lines, .write_protect_pin_n,
    .status_write_disable, .continuous_program_mode, .array_busy,
    .program_active, .protect_select_nv, .otp_lockdown_nv(1'b0),
    .factory_lock_nv(1'b0), .query_sector, .serial_out, .serial_out_en,
    .security_reg, .protection_select, .otp_lockdown_bit, .write_latch,
    .level_bits_frozen, .query_protected, .abort_operation, .device_ready);
  flash_host_model host (.clock, .serial_out, .chip_select_n,
    .serial_clock, .serial_in);
  // clock and noise on the unused data lines
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(negedge clock) upper_io_lines <= upper_io_lines + 3'h1;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic [7:0] code);
    host.frame({code, 24'h0}, 8, 1'b0, rx);
    repeat (12) @(negedge clock);
  endtask
  task automatic op_addr(input logic [7:0] code, input logic [23:0] addr,
                         input logic rd);
    host.frame({code, addr}, 32, rd, rx);
    repeat (12) @(negedge clock);
  endtask
  // armed reset, then count not-ready cycles
  task automatic soft_reset(input int lo);
    int low;
    int ab;
    low = 0;
    ab = 0;
    op(flash_protect_pkg::OP_RESET_ARM);
    host.frame({flash_protect_pkg::OP_RESET, 24'h0}, 8, 1'b0, rx);
    for (int i = 0; i < 80; i++) begin
      @(negedge clock);
      if (device_ready !== 1'b1) low++;
      if (abort_operation === 1'b1) ab++;
    end
    chk(low >= lo && low <= lo + 6, 1'b1);
    chk(8'(ab), {7'h00, array_busy});
  endtask
  task automatic final_report;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    reset = 1'b1;
    write_protect_pin_n = 1'b1;
    status_write_disable = 1'b0;
    continuous_program_mode = 1'b0;
    array_busy = 1'b0;
    program_active = 1'b0;
    protect_select_nv = 1'b0;
    query_sector = 12'h005;
    repeat (2) @(posedge clock);
    @(negedge clock) reset = 1'b0;
    repeat (8) @(negedge clock);
    chk(protection_select, 1'b0);
    chk(security_reg, 8'h00);
    op(flash_protect_pkg::OP_WRITE_SECURITY);
    chk(otp_lockdown_bit, 1'b0);
    op(flash_protect_pkg::OP_WRITE_LATCH_SET);
    op_addr(flash_protect_pkg::OP_BLOCK_LOCK, 24'h005000, 1'b0);
    chk(query_protected, 1'b0);
    status_write_disable = 1'b1;
    write_protect_pin_n = 1'b0;
    repeat (8) @(negedge clock);
    chk(level_bits_frozen, 1'b1);
    write_protect_pin_n = 1'b1;
    repeat (8) @(negedge clock);
    chk(level_bits_frozen, 1'b0);
    op(flash_protect_pkg::OP_WRITE_LATCH_SET);
    host.frame({flash_protect_pkg::OP_WRITE_SECURITY, 24'h0}, 9, 1'b0, rx);
    repeat (12) @(negedge clock);
    chk(otp_lockdown_bit, 1'b0);
    op(flash_protect_pkg::OP_WRITE_LATCH_SET);
    op(flash_protect_pkg::OP_WRITE_SECURITY);
    chk(otp_lockdown_bit, 1'b1);
    chk(write_latch, 1'b0);
    op(flash_protect_pkg::OP_PROTECT_SELECT);
    chk(protection_select, 1'b0);
    op(flash_protect_pkg::OP_WRITE_LATCH_SET);
    op(flash_protect_pkg::OP_PROTECT_SELECT);
    chk(security_reg[7], 1'b1);
    chk(query_protected, 1'b1);
    op(flash_protect_pkg::OP_WRITE_LATCH_SET);
    op_addr(flash_protect_pkg::OP_BLOCK_UNLOCK, 24'h005000, 1'b0);
    chk(query_protected, 1'b0);
    op_addr(flash_protect_pkg::OP_READ_BLOCK_LOCK, 24'h006000, 1'b1);
    chk(rx[0], 1'b1);
    op_addr(flash_protect_pkg::OP_READ_BLOCK_LOCK, 24'h005000, 1'b1);
    chk({rx[7], rx[0]}, 2'h0);
    op_addr(flash_protect_pkg::OP_BLOCK_LOCK, 24'h005000, 1'b0);
    chk(query_protected, 1'b0);
    op(flash_protect_pkg::OP_WRITE_LATCH_SET);
    host.frame({flash_protect_pkg::OP_GANG_LOCK, 24'h0}, 9, 1'b0, rx);
    repeat (12) @(negedge clock);
    chk(query_protected, 1'b0);
    op(flash_protect_pkg::OP_WRITE_LATCH_SET);
    op(flash_protect_pkg::OP_GANG_LOCK);
    chk(query_protected, 1'b1);
    op(flash_protect_pkg::OP_WRITE_LATCH_SET);
    op(flash_protect_pkg::OP_GANG_UNLOCK);
    chk(query_protected, 1'b0);
    write_protect_pin_n = 1'b0;
    repeat (8) @(negedge clock);
    chk(query_protected, 1'b1);
    write_protect_pin_n = 1'b1;
    op(flash_protect_pkg::OP_RESET_ARM);
    op(flash_protect_pkg::OP_NO_OPERATION);
    op(flash_protect_pkg::OP_RESET);
    chk({device_ready, query_protected}, 2'h2);
    soft_reset(REC);
    chk(query_protected, 1'b1);
    array_busy = 1'b1;
    program_active = 1'b1;
    soft_reset(REC_PROG);
    array_busy = 1'b0;
    program_active = 1'b0;
    chk(protection_select, 1'b1);
    chk(write_latch, 1'b0);
    continuous_program_mode = 1'b1;
    op(flash_protect_pkg::OP_BUSY_OUT_ENABLE);
    chk({serial_out_en, serial_out}, 2'h3);
    op(flash_protect_pkg::OP_BUSY_OUT_DISABLE);
    chk(serial_out_en, 1'b0);
    continuous_program_mode = 1'b0;
    protect_select_nv = 1'b1;
    reset = 1'b1;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    repeat (8) @(negedge clock);
    chk({protection_select, query_protected}, 2'h3);
    final_report();
  end
endmodule
`default_nettype wire
